// >>> serial_master_model.sv
`timescale 1ns/10ps
module serial_master_model (
  input wire mclk,
  input wire mode,
  input wire idle,
  input wire dout,
  input wire oe_n,
  output reg ce = 1'h0,
  output reg sclk = 1'h0,
  output wire line,
  output reg [7:0] rx = 8'h0,
  output reg rx_v = 1'h0
);
  reg d_r = 1'h0;
  reg drv_r = 1'h0;
  // Released, the shared line rises on its pull-up; an unused four-wire input shows a stale inverse.
  assign line = (!mode && !oe_n) ? dout : drv_r ? d_r : mode ? !d_r : 1'h1;
  task start;
    begin
      @(posedge mclk);
      sclk <= idle;
      repeat (4) @(posedge mclk);
      ce <= 1'h1;
      repeat (8) @(posedge mclk);
    end
  endtask
  task stop;
    begin
      repeat (4) @(posedge mclk);
      ce <= 1'h0;
      drv_r <= 1'h0;
      repeat (8) @(posedge mclk);
    end
  endtask
  task xbyte(input [7:0] tx, input drv);
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge mclk);
        sclk <= !idle;
        drv_r <= drv || mode;
        d_r <= mode ? tx[7 - i] : tx[i];
        repeat (4) @(posedge mclk);
        sclk <= idle;
        // A released four-wire output rests on its pull-up, so a late enable shows up as ones.
        rx <= mode ? {rx[6:0], oe_n ? 1'h1 : dout} : {line, rx[7:1]};
        repeat (3) @(posedge mclk);
      end
      @(posedge mclk);
      rx_v <= !drv;
      @(posedge mclk);
      rx_v <= 1'h0;
    end
  endtask
endmodule // serial_master_model

// >>> thermo_port_chk.sv
`timescale 1ns/10ps
module thermo_port_chk #(
  parameter CONV8_CYC = 100,
  parameter CONV12_CYC = 500
) (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire sclk,
  input wire serial_out_line_r,
  input wire serial_out_oe_n_r,
  input wire converting_r,
  input wire result_stored_r
);
  reg [31:0] run_r;
  // The pulse clears the count too; on a continuous restart the level drops only for the one cycle of the pulse.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_r <= 32'h0;
    end else begin
      run_r <= (!converting_r || result_stored_r) ? 32'h0 : run_r + 32'h1;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_gate_off: assert property (!ce [*5] |-> serial_out_oe_n_r)
    else $error("driven while gate low");
  a_oe_shift: assert property ($fell(serial_out_oe_n_r) |-> $past(sclk, 3) != $past(sclk, 4))
    else $error("enable off shift edge");
  a_bit_shift: assert property (
    !serial_out_oe_n_r && !$past(serial_out_oe_n_r) && $changed(serial_out_line_r) |->
    $past(sclk, 3) != $past(sclk, 4)) else $error("bit off shift edge");
  a_oe_hold: assert property (ce [*4] ##0 !serial_out_oe_n_r |=> !serial_out_oe_n_r)
    else $error("released mid read");
  a_store_pulse: assert property (result_stored_r |=> !result_stored_r)
    else $error("store pulse long");
  a_store_conv: assert property (result_stored_r |-> $past(converting_r))
    else $error("store without run");
  a_conv_max: assert property (converting_r |-> run_r <= CONV12_CYC + 4)
    else $error("run too long");
  a_conv_min: assert property (result_stored_r |-> $past(run_r) + 4 >= CONV8_CYC)
    else $error("run too short");
  c_store: cover property (result_stored_r);
  c_read: cover property ($fell(serial_out_oe_n_r));
  c_idle: cover property ($fell(converting_r));
endmodule // thermo_port_chk

bind thermometer_serial_register_port thermo_port_chk #(.CONV8_CYC(CONV8_CYC), .CONV12_CYC(CONV12_CYC)) u_chk (
  .mclk, .rst, .ce, .sclk, .serial_out_line_r, .serial_out_oe_n_r, .converting_r, .result_stored_r);

// >>> thermo_port_defines.vh
`ifndef THERMO_PORT_DEFINES_VH
`define THERMO_PORT_DEFINES_VH

// Register pointers after address decode.
`define ADDR_CONFIG 2'h0
`define ADDR_TEMP_LO 2'h1
`define ADDR_TEMP_HI 2'h2
`define ADDR_NONE 2'h3

// Address byte fields.
`define ADDR_DIR_BIT 7
`define ADDR_HI_MSB 6
`define ADDR_HI_LSB 2

// Configuration byte fields.
`define CFG_SD_BIT 0
`define CFG_RES_LSB 1
`define CFG_RES_MSB 3
`define CFG_ONE_BIT 4
`define CFG_TOP_ONES 3'h7

// Configuration reset values.
`define CFG_SD_RST 1'b1
`define CFG_RES_RST 3'h1
`define CFG_ONE_RST 1'b0

// Resolution codes.
`define RES_8 3'h0
`define RES_9 3'h1
`define RES_10 3'h2
`define RES_11 3'h3

// Result masks per resolution.
`define MASK_8 16'hff00
`define MASK_9 16'hff80
`define MASK_10 16'hffc0
`define MASK_11 16'hffe0
`define MASK_12 16'hfff0

// Longest conversion times in microseconds and the clock rate.
`define CONV8_US 75000
`define CONV9_US 150000
`define CONV10_US 300000
`define CONV11_US 600000
`define CONV12_US 1200000
`define CLK_MHZ 100

`endif

// >>> thermometer_serial_register_port.v
`timescale 1ns/10ps
`include "thermo_port_defines.vh"

// What this block does
// - Results two's complement, unused low bits zero
// - Decode 00h read, 80h write, 01h/02h read-only
// - Config: shutdown, resolution, one-shot, top ones
// - Config loads defaults at power-up
// - One-shot in shutdown converts once, then clears
// - One-shot writes ignored in continuous mode
// - Resolution codes select bits and conversion time
// - Resolution defaults to nine bits
// - Continuous mode keeps latest completed result
// - Shutdown finishes current conversion; port stays active
// - Shutdown bit read/write, powers up set
// - Strap high four-wire, low three-wire
// - Gate low resets transfer, output released
// - Clock level at gate rise is idle
// - Strobe edge captures, shift edge drives
// - One clock per bit, four-wire bytes MSB first
// - Three-wire mode moves bytes LSB first
// - Output released until data byte ready
// - First byte is address; top bit direction
// - Pointer advances per byte, wraps to config
// - Three-wire samples rising, drives falling
// - Three-wire shares one tied data line
module thermometer_serial_register_port #(
  parameter CONV8_CYC = `CONV8_US * `CLK_MHZ,
  parameter CONV9_CYC = `CONV9_US * `CLK_MHZ,
  parameter CONV10_CYC = `CONV10_US * `CLK_MHZ,
  parameter CONV11_CYC = `CONV11_US * `CLK_MHZ,
  parameter CONV12_CYC = `CONV12_US * `CLK_MHZ
) (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire sclk,
  input wire serial_in_line,
  input wire link_kind_strap,
  input wire [11:0] sensor_code,
  output reg serial_out_line_r,
  output reg serial_out_oe_n_r,
  output reg converting_r,
  output reg result_stored_r
);

  localparam CONV_IDLE = 1'b0;
  localparam CONV_BUSY = 1'b1;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [3:0] sync1_r;
  reg [3:0] sync2_r;
  reg ce_d_r;
  reg sclk_d_r;

  // Each pin reaches the logic two clocks late and the output answers one clock later, so every
  // half period of the serial clock must last longer than three system clocks or read bits reach the master late.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      ce_d_r <= 1'b0;
      sclk_d_r <= 1'b0;
    end else begin
      sync1_r <= {link_kind_strap, serial_in_line, sclk, ce};
      sync2_r <= sync1_r;
      ce_d_r <= sync2_r[0];
      sclk_d_r <= sync2_r[1];
    end
  end

  wire ce_q = sync2_r[0];
  wire sclk_q = sync2_r[1];
  wire sdi_q = sync2_r[2];
  wire strap_q = sync2_r[3];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  reg sd_r;
  reg [2:0] res_r;
  reg one_r;
  reg [7:0] temp_lo_r;
  reg [7:0] temp_hi_r;

  // Unmapped pointers read as zero, and a burst started there wraps to the configuration byte.
  function [7:0] reg_read;
    input [1:0] a;
    begin
      case (a)
        `ADDR_CONFIG: reg_read = {`CFG_TOP_ONES, one_r, res_r, sd_r};
        `ADDR_TEMP_LO: reg_read = temp_lo_r;
        `ADDR_TEMP_HI: reg_read = temp_hi_r;
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Serial transfer
  // ----------------------------------------------------------------
  // The strap is latched at each gate rise, so a change of link kind between transfers takes
  // effect at the next one and can never split a byte.
  reg idle_pol_r;
  reg spi_r;
  reg [2:0] bit_cnt_r;
  reg [7:0] rx_sr_r;
  reg have_addr_r;
  reg dir_wr_r;
  reg [1:0] ptr_r;
  reg [7:0] tx_sr_r;
  reg tx_arm_r;

  // Edges inside the gate only; the edge seen with the gate rise is
  // taken as the idle level, not as a bit.
  wire ce_rise = ce_q & ~ce_d_r;
  wire clk_edge = ce_q & ce_d_r & (sclk_q ^ sclk_d_r);
  wire strobe = clk_edge & (spi_r ? (sclk_q == idle_pol_r) : sclk_q);
  wire shift = clk_edge & (spi_r ? (sclk_q != idle_pol_r) : ~sclk_q);

  wire [7:0] rx_next = spi_r ? {rx_sr_r[6:0], sdi_q} : {sdi_q, rx_sr_r[7:1]};
  wire byte_done = strobe & (bit_cnt_r == 3'h7);
  wire addr_hit = (rx_next[`ADDR_HI_MSB:`ADDR_HI_LSB] == 5'h00) && (rx_next[1:0] != `ADDR_NONE);
  wire [1:0] addr_ptr = addr_hit ? rx_next[1:0] : `ADDR_NONE;
  wire [1:0] ptr_next = (ptr_r >= `ADDR_TEMP_HI) ? `ADDR_CONFIG : ptr_r + 2'h1;
  // Write data only ever lands in the configuration byte; the temperature bytes have no write
  // path, so a write aimed at them costs nothing but the pointer step.
  wire cfg_wr = byte_done & have_addr_r & dir_wr_r & (ptr_r == `ADDR_CONFIG);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      idle_pol_r <= 1'b0;
      spi_r <= 1'b0;
      bit_cnt_r <= 3'h0;
      rx_sr_r <= 8'h00;
      have_addr_r <= 1'b0;
      dir_wr_r <= 1'b0;
      ptr_r <= `ADDR_CONFIG;
      tx_sr_r <= 8'h00;
      tx_arm_r <= 1'b0;
      serial_out_line_r <= 1'b0;
      serial_out_oe_n_r <= 1'b1;
    end else if (!ce_q) begin
      // A byte cut short by the gate falling is dropped here; the next transfer starts afresh
      // with a new address byte.
      bit_cnt_r <= 3'h0;
      have_addr_r <= 1'b0;
      dir_wr_r <= 1'b0;
      tx_arm_r <= 1'b0;
      serial_out_oe_n_r <= 1'b1;
    end else begin
      if (ce_rise) begin
        idle_pol_r <= sclk_q;
        spi_r <= strap_q;
        bit_cnt_r <= 3'h0;
        have_addr_r <= 1'b0;
      end
      if (strobe) begin
        rx_sr_r <= rx_next;
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      // The read byte is captured on the last strobe of the byte before it, so a result stored
      // while a byte is shifting out is seen only from the next byte on.
      if (byte_done) begin
        if (!have_addr_r) begin
          have_addr_r <= 1'b1;
          dir_wr_r <= rx_next[`ADDR_DIR_BIT];
          ptr_r <= addr_ptr;
          if (!rx_next[`ADDR_DIR_BIT]) begin
            tx_sr_r <= reg_read(addr_ptr);
            tx_arm_r <= 1'b1;
          end
        end else begin
          ptr_r <= ptr_next;
          if (!dir_wr_r) begin
            tx_sr_r <= reg_read(ptr_next);
          end
        end
      end
      // The output stays released until a whole byte sits in the shifter.
      if (shift && tx_arm_r) begin
        serial_out_line_r <= spi_r ? tx_sr_r[7] : tx_sr_r[0];
        tx_sr_r <= spi_r ? {tx_sr_r[6:0], 1'b0} : {1'b0, tx_sr_r[7:1]};
        serial_out_oe_n_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  // One down-counter serves every resolution; it is wide enough for the longest conversion at
  // this clock rate, which is the price of keeping the times exact rather than prescaled.
  reg conv_state_r;
  reg [31:0] conv_cnt_r;
  reg conv_one_r;
  reg [2:0] conv_res_r;
  wire conv_fin = (conv_state_r == CONV_BUSY) && (conv_cnt_r == 32'h0);
  // The request is judged against the shutdown bit held before this same write, so a write
  // that sets both bits together starts a conversion only if the device was already shut
  // down; in continuous mode the request would be meaningless.
  wire one_set = cfg_wr & sd_r & rx_next[`CFG_ONE_BIT];

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sd_r <= `CFG_SD_RST;
      res_r <= `CFG_RES_RST;
      one_r <= `CFG_ONE_RST;
    end else begin
      if (cfg_wr) begin
        sd_r <= rx_next[`CFG_SD_BIT];
        res_r <= rx_next[`CFG_RES_MSB:`CFG_RES_LSB];
      end
      // A request landing on the completion cycle survives the clear.
      if (one_set) begin
        one_r <= 1'b1;
      end else if (conv_fin && conv_one_r) begin
        one_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  reg [31:0] lim_sel;
  reg [15:0] res_mask;

  // The resolution is latched when a conversion starts, so a change made while one runs
  // applies only to the next result.

  always @* begin
    case (res_r)
      `RES_8: lim_sel = CONV8_CYC;
      `RES_9: lim_sel = CONV9_CYC;
      `RES_10: lim_sel = CONV10_CYC;
      `RES_11: lim_sel = CONV11_CYC;
      default: lim_sel = CONV12_CYC;
    endcase
  end

  always @* begin
    case (conv_res_r)
      `RES_8: res_mask = `MASK_8;
      `RES_9: res_mask = `MASK_9;
      `RES_10: res_mask = `MASK_10;
      `RES_11: res_mask = `MASK_11;
      default: res_mask = `MASK_12;
    endcase
  end

  // The sensor code is already two's complement in sixteenths; it is
  // left-aligned so the sign lands in the top bit of the high byte.
  wire [15:0] result = {sensor_code, 4'h0} & res_mask;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      conv_state_r <= CONV_IDLE;
      conv_cnt_r <= 32'h0;
      conv_one_r <= 1'b0;
      conv_res_r <= `CFG_RES_RST;
      temp_lo_r <= 8'h00;
      temp_hi_r <= 8'h00;
      converting_r <= 1'b0;
      result_stored_r <= 1'b0;
    end else begin
      result_stored_r <= 1'b0;
      case (conv_state_r)
        CONV_IDLE: begin
          if (!sd_r || one_r) begin
            conv_state_r <= CONV_BUSY;
            conv_cnt_r <= lim_sel - 32'h1;
            conv_res_r <= res_r;
            conv_one_r <= sd_r;
            converting_r <= 1'b1;
          end
        end
        CONV_BUSY: begin
          // Shutdown set mid-conversion does not abort it.
          if (conv_cnt_r == 32'h0) begin
            temp_lo_r <= result[7:0];
            temp_hi_r <= result[15:8];
            result_stored_r <= 1'b1;
            conv_state_r <= CONV_IDLE;
            converting_r <= 1'b0;
          end else begin
            conv_cnt_r <= conv_cnt_r - 32'h1;
          end
        end
        default: begin
          conv_state_r <= CONV_IDLE;
          converting_r <= 1'b0;
        end
      endcase
    end
  end

endmodule // thermometer_serial_register_port

// >>> thermometer_serial_register_port_tb.sv
`timescale 1ns/10ps
module thermometer_serial_register_port_tb;
  reg mclk = 1'h0;
  reg rst = 1'h1;
  reg strap = 1'h1;
  reg idle = 1'h0;
  reg [11:0] code = 12'h0;
  reg [31:0] seed = 32'h5;
  integer n_fail = 0;
  integer checks = 0;
  integer r;
  logic [7:0] q[$];
  wire ce, sclk, line, serial_out_line, oe_n, conv, stored, rx_v;
  wire [7:0] rx;
  always #5 mclk = ~mclk;
  thermometer_serial_register_port #(.CONV8_CYC(100), .CONV9_CYC(200), .CONV10_CYC(300), .CONV11_CYC(400),
    .CONV12_CYC(500)) i_dut (.mclk, .rst, .ce, .sclk, .serial_in_line(line), .link_kind_strap(strap),
    .sensor_code(code), .serial_out_line_r(serial_out_line), .serial_out_oe_n_r(oe_n), .converting_r(conv),
    .result_stored_r(stored));
  serial_master_model i_mst (.mclk, .mode(strap), .idle, .dout(serial_out_line), .oe_n, .ce, .sclk, .line, .rx, .rx_v);
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task check(input [7:0] seen, input [7:0] want);
    begin
      checks = checks + 1;
      if (seen !== want) begin
        n_fail = n_fail + 1;
        $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  task xfer(input [7:0] a, input integer n, input [23:0] d);
    integer k;
    begin
      i_mst.start;
      i_mst.xbyte(a, 1'h1);
      for (k = 0; k < n; k = k + 1) begin
        seed = xs(seed);
        if (!a[7]) q.push_back(d[8 * k +: 8]);
        i_mst.xbyte(a[7] ? d[8 * k +: 8] : seed[7:0], a[7]);
      end
      i_mst.stop;
    end
  endtask
  task new_code;
    begin
      @(posedge mclk);
      seed = xs(seed);
      code <= seed[11:0];
      @(posedge mclk);
    end
  endtask
  task wait_st;
    integer w;
    begin
      w = 0;
      while (stored !== 1'h1 && w < 2000) begin
        @(posedge mclk);
        w = w + 1;
      end
      check({7'h0, stored}, 8'h01);
    end
  endtask
  always @(posedge mclk) begin
    if (rx_v) check(rx, q.pop_front());
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'h0;
    repeat (5) @(posedge mclk);
    xfer(8'h00, 1, 24'he3);
    check({7'h0, conv}, 8'h00);
    $display("t1 done");
    new_code;
    xfer(8'h80, 1, 24'h11);
    wait_st;
    xfer(8'h01, 3, {8'he1, code[11:4], 8'h00});
    $display("t2 done");
    strap <= 1'h0;
    idle <= 1'h1;
    new_code;
    xfer(8'h80, 1, 24'h19);
    wait_st;
    xfer(8'h01, 3, {8'he9, code, 4'h0});
    xfer(8'h81, 3, 24'he355aa);
    xfer(8'h00, 3, {code, 4'h0, 8'he3});
    $display("t3 done");
    strap <= 1'h1;
    xfer(8'h80, 1, 24'h00);
    xfer(8'h80, 1, 24'h10);
    xfer(8'h00, 1, 24'he0);
    new_code;
    wait_st;
    new_code;
    wait_st;
    xfer(8'h01, 2, {code[11:4], 8'h00});
    new_code;
    xfer(8'h80, 1, 24'h01);
    repeat (150) @(posedge mclk);
    check({7'h0, conv}, 8'h00);
    xfer(8'h01, 2, {code[11:4], 8'h00});
    $display("t4 done");
    for (r = 1; r < 4; r = r + 1) begin
      new_code;
      xfer(8'h80, 1, {19'h0, 1'h1, r[2:0], 1'h1});
      wait_st;
      xfer(8'h01, 3, {3'h7, 1'h0, r[2:0], 1'h1, code[11:4], {code[3:0], 4'h0} & ~(8'hff >> r)});
    end
    $display("t5 done");
    check(8'(q.size()), 8'h00);
    wrap_up;
  end
  // The tests need under 10000 cycles; the watchdog allows ten times that before a hang is declared.
  initial begin
    #1000000;
    n_fail = n_fail + 1;
    wrap_up;
  end
endmodule // thermometer_serial_register_port_tb
